// [hw/ccer_pkg.sv]
// Purpose: Constants for the calibration coefficient and excitation register bank
// Assumes: Byte-wide registers, one per aligned Wishbone word
// Notes: Offsets are printed register indices; byte address is index times four
package ccer_pkg;
    localparam int CCER_DW = 24;
    localparam logic [7:0] CCER_IDX_OFC0 = 8'h04;
    localparam logic [7:0] CCER_IDX_OFC1 = 8'h05;
    localparam logic [7:0] CCER_IDX_OFC2 = 8'h06;
    localparam logic [7:0] CCER_IDX_FSC0 = 8'h07;
    localparam logic [7:0] CCER_IDX_FSC1 = 8'h08;
    localparam logic [7:0] CCER_IDX_FSC2 = 8'h09;
    localparam logic [7:0] CCER_IDX_EXC0 = 8'h0a;
    localparam logic [7:0] CCER_IDX_EXC1 = 8'h0b;
    localparam logic [7:0] CCER_IDX_GAIN = 8'h03;
    localparam logic [7:0] CCER_IDX_DATA = 8'h10;
    localparam logic [7:0] CCER_IDX_STAT = 8'h11;
    localparam int CCER_REV_LSB = 4;
    localparam int CCER_MODE_BIT = 3;
    localparam int CCER_GAIN_LSB = 4;
    localparam logic [23:0] CCER_OFC_RST = 24'h000000;
    localparam logic [7:0] CCER_EXC1_RST = 8'hff;
    localparam logic [2:0] CCER_GAIN_RST = 3'h0;
    localparam logic [2:0] CCER_MAG_RST = 3'h0;
    localparam int CCER_FS_SHIFT = 22;
    localparam logic [3:0] CCER_REV_DEFAULT = 4'h5;
endpackage

// [hw/ccer_regs.sv]
// Purpose: Offset and full-scale calibration, ready-pin mode and excitation register bank
// Assumes: Classic Wishbone slave, byte registers in low bits of aligned words
// Notes: Conversion results arrive as a same-clock strobe with data
//
// Behaviour
// - Offset is 24-bit signed, aligned with result
// - Subtract offset before full-scale correction
// - Full-scale unsigned, scale is value over 400000h
// - Multiply corrected result by scale factor
// - Reload trimmed full-scale on reset, gain change
// - Offset resets zero, all bytes read/write
// - Read-only revision in upper bits
// - Mode bit selects data-only or data-plus-ready pin
// - Dedicated ready pin always signals data, low
// - Magnitude 000 off, 001 50uA, 010 100uA
// - Source one routing: inputs, pins, disconnect
// - Source two routing uses same encoding
// - Routing register resets to all ones
// - Gain field three bits, gains 1 to 128
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ccer_regs
    import ccer_pkg::*;
#(
    parameter logic [3:0] SILICON_REVISION = CCER_REV_DEFAULT, // Arbitrary value
    parameter logic [191:0] FS_TRIM = {8{24'h400000}}
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic raw_valid_i,
    input wire logic [23:0] raw_result_i,
    input wire logic dout_bit_i,
    input wire logic idle_i,
    output logic [23:0] cal_result_o,
    output logic cal_valid_o,
    output logic dedicated_ready_pin_n_o,
    output logic shared_out_ready_pin_o,
    output logic [2:0] excitation_magnitude_o,
    output logic [10:0] source1_current_ua_o,
    output logic [3:0] source1_route_o,
    output logic [3:0] source2_route_o,
    output logic [7:0] source1_dest_onehot_o,
    output logic [7:0] source2_dest_onehot_o,
    output logic source1_pin_a_o,
    output logic source1_pin_b_o,
    output logic source2_pin_a_o,
    output logic source2_pin_b_o
);
    logic [23:0] offset_coefficient;
    logic [23:0] fullscale_coefficient;
    logic [2:0] gain_setting;
    logic ready_on_dout_select;
    logic [7:0] routing;
    logic data_pending;

    // Route decode; shared by both sources
    function automatic logic [9:0] ccer_route(input logic [3:0] code);
        logic [9:0] r;
        r = 10'h000;
        if (code[3] == 1'b0)
            r[code[2:0]] = 1'b1;
        else if (code[2] == 1'b0)
            r[8 + 32'(code[0])] = 1'b1;
        return r;
    endfunction

    function automatic logic [10:0] ccer_ua(input logic [2:0] m);
        case (m)
            3'h1: return 11'd50;
            3'h2: return 11'd100;
            3'h3: return 11'd250;
            3'h4: return 11'd500;
            3'h5: return 11'd750;
            3'h6: return 11'd1000;
            default: return 11'd0;
        endcase
    endfunction

    wire logic [7:0] idx = adr_i[9:2];
    wire logic wr = cyc_i && stb_i && we_i && sel_i[0] && !ack_o;
    wire logic rd_cycle = cyc_i && stb_i && !ack_o;
    wire logic [7:0] wb = dat_i[7:0];
    wire logic [23:0] trim = FS_TRIM[24 * gain_setting +: 24];
    wire logic [2:0] next_gain = wb[CCER_GAIN_LSB +: 3];
    wire logic gain_change = wr && idx == CCER_IDX_GAIN && next_gain != gain_setting;

    // Offset corrected first, then scaled; widths hold the full signed product
    wire logic signed [24:0] corrected =
        $signed({raw_result_i[23], raw_result_i}) - $signed({offset_coefficient[23],
        offset_coefficient});
    wire logic signed [49:0] product =
        corrected * $signed({1'b0, fullscale_coefficient});
    wire logic signed [49:0] scaled = product >>> CCER_FS_SHIFT;
    wire logic over = scaled > 50'sh7fffff;
    wire logic under = scaled < -50'sh800000;
    wire logic [23:0] sat = over ? 24'h7fffff : under ? 24'h800000 : scaled[23:0];

    wire logic [9:0] r1 = ccer_route(routing[7:4]);
    wire logic [9:0] r2 = ccer_route(routing[3:0]);

    logic [7:0] rd_byte;
    always_comb
    begin
        case (idx)
            CCER_IDX_OFC0: rd_byte = offset_coefficient[7:0];
            CCER_IDX_OFC1: rd_byte = offset_coefficient[15:8];
            CCER_IDX_OFC2: rd_byte = offset_coefficient[23:16];
            CCER_IDX_FSC0: rd_byte = fullscale_coefficient[7:0];
            CCER_IDX_FSC1: rd_byte = fullscale_coefficient[15:8];
            CCER_IDX_FSC2: rd_byte = fullscale_coefficient[23:16];
            CCER_IDX_GAIN: rd_byte = {1'b0, gain_setting, 4'h0};
            CCER_IDX_EXC0: rd_byte = {SILICON_REVISION, ready_on_dout_select,
                excitation_magnitude_o};
            CCER_IDX_EXC1: rd_byte = routing;
            CCER_IDX_DATA: rd_byte = cal_result_o[7:0];
            CCER_IDX_STAT: rd_byte = {7'h00, data_pending};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end
        else
        begin
            ack_o <= rd_cycle;
            dat_o <= {24'h0, rd_byte};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            offset_coefficient <= CCER_OFC_RST;
            gain_setting <= CCER_GAIN_RST;
            fullscale_coefficient <= FS_TRIM[23:0];
            ready_on_dout_select <= 1'b0;
            excitation_magnitude_o <= CCER_MAG_RST;
            routing <= CCER_EXC1_RST;
        end
        else if (wr)
        begin
            case (idx)
                CCER_IDX_OFC0: offset_coefficient[7:0] <= wb;
                CCER_IDX_OFC1: offset_coefficient[15:8] <= wb;
                CCER_IDX_OFC2: offset_coefficient[23:16] <= wb;
                CCER_IDX_FSC0: fullscale_coefficient[7:0] <= wb;
                CCER_IDX_FSC1: fullscale_coefficient[15:8] <= wb;
                CCER_IDX_FSC2: fullscale_coefficient[23:16] <= wb;
                CCER_IDX_GAIN:
                begin
                    gain_setting <= next_gain;
                    if (gain_change)
                        fullscale_coefficient <= FS_TRIM[24 * next_gain +: 24];
                end
                CCER_IDX_EXC0:
                begin
                    // Upper nibble is fixed by SILICON_REVISION, so writes there vanish
                    ready_on_dout_select <= wb[CCER_MODE_BIT];
                    excitation_magnitude_o <= wb[2:0];
                end
                CCER_IDX_EXC1: routing <= wb;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cal_result_o <= 24'h0;
            cal_valid_o <= 1'b0;
            data_pending <= 1'b0;
        end
        else
        begin
            cal_valid_o <= raw_valid_i;
            if (raw_valid_i)
                cal_result_o <= sat;
            // New result wins over a read of the data register in the same cycle
            if (raw_valid_i)
                data_pending <= 1'b1;
            else if (rd_cycle && !we_i && idx == CCER_IDX_DATA)
                data_pending <= 1'b0;
        end
    end

    assign dedicated_ready_pin_n_o = !data_pending;
    assign shared_out_ready_pin_o = (ready_on_dout_select && idle_i) ?
        !data_pending : dout_bit_i;
    assign source1_current_ua_o = ccer_ua(excitation_magnitude_o);
    assign source1_route_o = routing[7:4];
    assign source2_route_o = routing[3:0];
    assign source1_dest_onehot_o = r1[7:0];
    assign source2_dest_onehot_o = r2[7:0];
    assign source1_pin_a_o = r1[8];
    assign source1_pin_b_o = r1[9];
    assign source2_pin_a_o = r2[8];
    assign source2_pin_b_o = r2[9];
    wire logic unused = &{1'b0, trim, sel_i[3:1], dat_i[31:8], adr_i[1:0]};
endmodule
`default_nettype wire

// [testbench/ccer_regs_checker.sv]
// Purpose: Port-level properties of the register bank
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every instance of the bank
`timescale 1ns/1ps
`default_nettype none
module ccer_regs_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic raw_valid_i,
    input wire logic cal_valid_o,
    input wire logic dedicated_ready_pin_n_o,
    input wire logic idle_i,
    input wire logic dout_bit_i,
    input wire logic shared_out_ready_pin_o,
    input wire logic [3:0] source1_route_o,
    input wire logic [3:0] source2_route_o,
    input wire logic [7:0] source1_dest_onehot_o,
    input wire logic [7:0] source2_dest_onehot_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff rst_i;
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    ack_pulse_a: assert property (s_req |=> ack_o ##1 !ack_o) else $error("ack pulse");
    result_valid_a: assert property (raw_valid_i |=> cal_valid_o) else $error("valid");
    ready_low_a: assert property (cal_valid_o |-> !dedicated_ready_pin_n_o) else $error("ready");
    shared_data_a: assert property (!idle_i |-> shared_out_ready_pin_o == dout_bit_i)
        else $error("shared pin");
    src1_off_a: assert property (source1_route_o[3:2] == 2'b11 |-> source1_dest_onehot_o == 8'h00)
        else $error("src1 off");
    src1_input_a: assert property (!source1_route_o[3] |->
        source1_dest_onehot_o == (8'h01 << source1_route_o[2:0])) else $error("src1 input");
    src2_off_a: assert property (source2_route_o[3:2] == 2'b11 |-> source2_dest_onehot_o == 8'h00)
        else $error("src2 off");
    route_reset_a: assert property ($past(rst_i) |-> {source1_route_o, source2_route_o} == 8'hff)
        else $error("route reset");
endmodule
bind ccer_regs ccer_regs_checker i_ccer_regs_checker (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .raw_valid_i(raw_valid_i),
    .cal_valid_o(cal_valid_o), .dedicated_ready_pin_n_o(dedicated_ready_pin_n_o),
    .idle_i(idle_i), .dout_bit_i(dout_bit_i), .shared_out_ready_pin_o(shared_out_ready_pin_o),
    .source1_route_o(source1_route_o), .source2_route_o(source2_route_o),
    .source1_dest_onehot_o(source1_dest_onehot_o), .source2_dest_onehot_o(source2_dest_onehot_o));
`default_nettype wire

// [testbench/ccer_host_model.sv]
// Purpose: Serial-side stand-in for the shifter and host
// Assumes: Shares the bank clock
// Notes: Data toggles on three cycles in every four, so a stale bit passes for a match on one cycle in four
`timescale 1ns/1ps
`default_nettype none
module ccer_host_model (
    input wire logic clk_i,
    output logic dout_bit_o,
    output logic idle_o
);
    logic [3:0] phase = 4'h0;
    always_ff @(posedge clk_i) phase <= phase + 4'h1;
    // Host only reads the combined pin in idle gaps of a normal read mode
    assign idle_o = phase[3];
    assign dout_bit_o = phase[0] ^ phase[2];
endmodule
`default_nettype wire

// [testbench/test_cal_coeff_excitation_regs.sv]
// Purpose: Directed scenarios for the register bank
// Assumes: Byte registers at index times four, ack one cycle after request
// Notes: Gain-one trim differs from gain-zero so a reload is visible
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_total++; \
    $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module test_cal_coeff_excitation_regs
    import ccer_pkg::*;
;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, raw_valid_i = 0, ack_o, cal_valid_o;
    logic [9:0] adr_i = '0;
    logic [31:0] dat_i = '0, dat_o;
    logic [23:0] raw_result_i = '0, cal_result_o;
    logic dedicated_ready_pin_n_o, shared_out_ready_pin_o, s1a, s2b;
    logic [2:0] excitation_magnitude_o;
    logic [10:0] source1_current_ua_o;
    logic [7:0] s1_hot, s2_hot, rd;
    wire logic dout_bit_i, idle_i;
    int err_total = 0, tests_run = 0;
    ccer_regs #(.FS_TRIM({{6{24'h400000}}, 24'h300000, 24'h400000})) i_ccer_regs (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .raw_valid_i(raw_valid_i),
        .raw_result_i(raw_result_i), .dout_bit_i(dout_bit_i), .idle_i(idle_i),
        .cal_result_o(cal_result_o), .cal_valid_o(cal_valid_o),
        .dedicated_ready_pin_n_o(dedicated_ready_pin_n_o),
        .shared_out_ready_pin_o(shared_out_ready_pin_o),
        .excitation_magnitude_o(excitation_magnitude_o), .source1_current_ua_o(source1_current_ua_o),
        .source1_route_o(), .source2_route_o(), .source1_dest_onehot_o(s1_hot),
        .source2_dest_onehot_o(s2_hot), .source1_pin_a_o(s1a), .source1_pin_b_o(),
        .source2_pin_a_o(), .source2_pin_b_o(s2b));
    ccer_host_model i_ccer_host_model (.clk_i(clk_i), .dout_bit_o(dout_bit_i), .idle_o(idle_i));
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic report_and_stop();
        if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, idx, 2'b00, 24'h0, wd};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 16);
        rd = dat_o[7:0];
        {cyc_i, stb_i} <= 2'b00;
        if (n >= 16)
        begin
            err_total++;
            report_and_stop();
        end
    endtask
    task automatic chk_rd(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        `CHK("register", e, rd)
    endtask
    task automatic convert(input logic [23:0] v, input logic [23:0] e);
        @(posedge clk_i);
        {raw_valid_i, raw_result_i} <= {1'b1, v};
        @(posedge clk_i);
        raw_valid_i <= 1'b0;
        @(negedge clk_i);
        `CHK("result", e, cal_result_o)
        `CHK("ready pin", 1'b0, dedicated_ready_pin_n_o)
    endtask
    task automatic t_reset();
        chk_rd(8'h04, 8'h00);
        chk_rd(8'h06, 8'h00);
        chk_rd(8'h0b, 8'hff);
        chk_rd(8'h0a, {CCER_REV_DEFAULT, 4'h0});
        chk_rd(8'h0c, 8'h00);
    endtask
    task automatic t_calib();
        bus(1'b1, 8'h04, 8'h03);
        chk_rd(8'h04, 8'h03);
        convert(24'h000010, 24'h00000d);
        bus(1'b1, 8'h09, 8'h80);
        convert(24'h000010, 24'h00001a);
        bus(1'b1, 8'h03, 8'h10);
        chk_rd(8'h09, 8'h30);
        chk_rd(8'h07, 8'h00);
    endtask
    task automatic t_ctrl();
        logic [10:0] ua[8] = '{0, 50, 100, 250, 500, 750, 1000, 0};
        int n;
        for (int c = 0; c < 8; c++)
        begin
            bus(1'b1, 8'h0a, 8'hf0 | 8'(c));
            `CHK("current", ua[c], source1_current_ua_o)
        end
        chk_rd(8'h0a, {CCER_REV_DEFAULT, 4'h7});
        bus(1'b1, 8'h0a, 8'h0a);
        `CHK("magnitude", 3'h2, excitation_magnitude_o)
        n = 0;
        while (idle_i !== 1'b1 && n < 32)
        begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 32)
        begin
            err_total++;
            report_and_stop();
        end
        `CHK("shared pin", 1'b0, shared_out_ready_pin_o)
        chk_rd(8'h11, 8'h01);
        chk_rd(8'h10, 8'h1a);
        `CHK("ready idle", 1'b1, dedicated_ready_pin_n_o)
    endtask
    task automatic t_route();
        bus(1'b1, 8'h0b, 8'h8b);
        `CHK("pin a", 1'b1, s1a)
        `CHK("pin b", 1'b1, s2b)
        bus(1'b1, 8'h0b, 8'h25);
        `CHK("dest one", 8'h04, s1_hot)
        `CHK("dest two", 8'h20, s2_hot)
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_calib();
        t_ctrl();
        t_route();
        report_and_stop();
    end
endmodule
`default_nettype wire
